// ==== pfrm_crc16.v ====
`timescale 1ns/1ps
`include "pfrm_regs.vh"
// Bit-serial sixteen-bit check sequence, one bit per enabled cycle
module pfrm_crc16 (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Control
    input wire init,
    input wire en,
    input wire bitIn,
    // Running value
    output reg [15:0] crc_r
);
    // Feedback term of the reflected shift
    wire fb = crc_r[0] ^ bitIn;

    // Init wins over a shift in the same cycle
    always @(posedge core_clk) begin
        if (!rst_n) begin
            crc_r <= `PFRM_CRC_INIT;
        end else if (init) begin
            crc_r <= `PFRM_CRC_INIT;
        end else if (en) begin
            crc_r <= {1'b0, crc_r[15:1]} ^ (fb ? `PFRM_CRC_POLY : 16'h0000);
        end
    end
endmodule

// ==== pfrm_framer.v ====
// Notes on behaviour
// - Separate transmit and receive buffers, 64x16
// - Payload never exceeds 125 bytes
// - Send four-byte preamble, delimiter, length first
// - Check sequence follows last payload byte
// - Parse header, store payload and check sequence
// - Recompute check sequence, report pass or fail
// - Link quality over 64 us after preamble
// - Interrupt only after whole packet stored
// - Channel check from integrated baseband energy
// - Send buffer, interrupt when fully sent
// - Serial port and one interrupt line only
`timescale 1ns/1ps
`include "pfrm_regs.vh"
module pfrm_framer #(
    parameter [15:0] LQI_CYC = `PFRM_LQI_CYC,
    parameter [15:0] CCA_CYC = `PFRM_CCA_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Host serial port
    input wire spiClk,
    input wire spiCsN,
    input wire spiMosi,
    output reg spiMiso_r,
    output reg spiMisoEn_r,
    // Host interrupt, active low
    output reg irqN_r,
    // Link side
    input wire linkClk,
    input wire linkRxData,
    output reg txData_r,
    output reg txActive_r,
    // Baseband energy level, core clock domain
    input wire [7:0] bbEnergy
);
    localparam TS_IDLE = 3'd0, TS_PRE = 3'd1, TS_SFD = 3'd2, TS_LEN = 3'd3;
    localparam TS_PAY = 3'd4, TS_FCS = 3'd5, TS_TAIL = 3'd6;
    localparam RS_HUNT = 2'd0, RS_LEN = 2'd1, RS_PAY = 2'd2, RS_FIN = 2'd3;
    localparam SUMW = 24;

    // Pick one byte of a buffer word, low byte first
    function [7:0] byteOf;
        input [15:0] word;
        input hi;
        begin
            byteOf = hi ? word[15:8] : word[7:0];
        end
    endfunction

    reg [15:0] txRam [0:`PFRM_RAM_WORDS-1];
    reg [15:0] rxRam [0:`PFRM_RAM_WORDS-1];

    // Synchronisers: spiClk, spiCsN, spiMosi, linkClk, linkRxData
    wire [4:0] pinIn = {linkRxData, linkClk, spiMosi, spiCsN, spiClk};
    reg [4:0] syn1_r, syn2_r, syn3_r, stab_r, prev_r;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            syn1_r <= 5'h02;
            syn2_r <= 5'h02;
            syn3_r <= 5'h02;
            prev_r <= 5'h02;
        end else begin
            syn1_r <= pinIn;
            syn2_r <= syn1_r;
            syn3_r <= syn2_r;
            prev_r <= stab_r;
        end
    end
    // A level is taken only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : gStab
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    stab_r[gi] <= (gi == 1);
                end else if (syn2_r[gi] == syn3_r[gi]) begin
                    stab_r[gi] <= syn3_r[gi];
                end
            end
        end
    endgenerate
    wire sclkRise = stab_r[0] & ~prev_r[0];
    wire sclkFall = ~stab_r[0] & prev_r[0];
    wire csN = stab_r[1];
    wire mosi = stab_r[2];
    wire lclkRise = stab_r[3] & ~prev_r[3];
    wire lclkFall = ~stab_r[3] & prev_r[3];
    wire rxBit = stab_r[4];

    // Serial port state
    reg [4:0] spiCnt_r;         // Rising edges seen in this transfer
    reg [22:0] spiIn_r;         // Bits shifted in so far
    reg [15:0] spiOut_r;        // Read data, MSB first
    reg cmdRead_r;              // Command bit 7
    reg statRd;                 // Status read pulse, clears flags
    reg [6:0] txLen_r;          // Payload bytes to send
    reg rxEn_r;                 // Receiver enabled
    reg txGo, ccaGo;            // One-cycle requests
    reg txDone_r, rxDone_r, crcOk_r, ccaDone_r;
    reg [6:0] rxLen_r;          // Received length field
    reg [7:0] ccaLvl_r;         // Last channel energy result
    wire [7:0] cmdNow = {spiIn_r[6:0], mosi};
    wire [23:0] xferNow = {spiIn_r, mosi};
    wire [6:0] wrAddr = xferNow[22:16];
    wire [15:0] wrData = xferNow[15:0];
    wire [6:0] wrLen = wrData[14:8];

    // Read multiplexer for the addressed word
    reg [15:0] rdWord;
    always @* begin
        rdWord = 16'h0000;
        if (cmdNow[`PFRM_RAM_SEL]) begin
            rdWord = rxRam[cmdNow[5:0]];
        end else if (cmdNow[6:0] == `PFRM_ADDR_CTRL) begin
            rdWord = {1'b0, txLen_r, 6'h00, rxEn_r, 1'b0};
        end else if (cmdNow[6:0] == `PFRM_ADDR_STAT) begin
            rdWord = {1'b0, rxLen_r, 3'h0, txActive_r, ccaDone_r,
                      crcOk_r, rxDone_r, txDone_r};
        end else if (cmdNow[6:0] == `PFRM_ADDR_CCA) begin
            rdWord = {8'h00, ccaLvl_r};
        end
    end

    // all host traffic: 8-bit command then 16-bit word, mode 0
    always @(posedge core_clk) begin
        if (!rst_n) begin
            spiCnt_r <= 5'h00;
            spiIn_r <= 23'h00_0000;
            spiOut_r <= 16'h0000;
            cmdRead_r <= 1'b0;
            statRd <= 1'b0;
            txGo <= 1'b0;
            ccaGo <= 1'b0;
            txLen_r <= 7'h00;
            rxEn_r <= 1'b0;
            spiMiso_r <= 1'b0;
            spiMisoEn_r <= 1'b0;
        end else begin
            statRd <= 1'b0;
            txGo <= 1'b0;
            ccaGo <= 1'b0;
            spiMisoEn_r <= ~csN;
            spiMiso_r <= spiOut_r[15];
            if (csN) begin
                // Deselect aborts any partial transfer
                spiCnt_r <= 5'h00;
                spiOut_r <= 16'h0000;
            end else if (sclkRise) begin
                spiIn_r <= xferNow[22:0];
                spiCnt_r <= spiCnt_r + 5'h01;
                if (spiCnt_r == `PFRM_CMD_BITS - 5'h01) begin
                    // Command complete: fetch read data now
                    cmdRead_r <= cmdNow[7];
                    if (cmdNow[7]) begin
                        spiOut_r <= rdWord;
                        statRd <= (cmdNow[6:0] == `PFRM_ADDR_STAT);
                    end
                end else if (spiCnt_r == `PFRM_SPI_BITS - 5'h01 &&
                             !cmdRead_r && !wrAddr[`PFRM_RAM_SEL] &&
                             wrAddr == `PFRM_ADDR_CTRL) begin
                    // clamp the payload length to 125
                    txLen_r <= (wrLen > `PFRM_MAX_PAYLOAD) ?
                               `PFRM_MAX_PAYLOAD : wrLen;
                    rxEn_r <= wrData[`PFRM_CTRL_RXEN];
                    // start request comes after the buffer load
                    txGo <= wrData[`PFRM_CTRL_TXGO];
                    ccaGo <= wrData[`PFRM_CTRL_CCAGO];
                end
            end else if (sclkFall && spiCnt_r > `PFRM_CMD_BITS) begin
                // Next read bit ready before the next rising edge
                spiOut_r <= {spiOut_r[14:0], 1'b0};
            end
        end
    end

    // Host writes into the transmit buffer; no reset needed on storage
    always @(posedge core_clk) begin
        if (!csN && sclkRise && spiCnt_r == `PFRM_SPI_BITS - 5'h01 &&
            !cmdRead_r && wrAddr[`PFRM_RAM_SEL]) begin
            txRam[wrAddr[5:0]] <= wrData;
        end
    end

    // Transmit framing
    reg [2:0] tState_r;
    reg [4:0] tBit_r;           // Bit within current field
    reg [6:0] tByte_r;          // Payload byte index
    wire [15:0] txCrc;
    reg [7:0] tCur;             // Byte now being sent
    reg tEnd;                   // Last bit of current field
    always @* begin
        tCur = 8'h00;
        tEnd = (tBit_r[2:0] == 3'h7);
        case (tState_r)
            TS_PRE: tEnd = (tBit_r == `PFRM_PRE_BITS - 5'h01);
            TS_SFD: tCur = `PFRM_SFD;
            // length counts the check sequence too
            TS_LEN: tCur = {1'b0, txLen_r} + `PFRM_FCS_BYTES;
            TS_PAY: tCur = byteOf(txRam[tByte_r[6:1]], tByte_r[0]);
            TS_FCS: tEnd = (tBit_r == 5'h0F);
            default: tEnd = 1'b0;
        endcase
    end
    wire tBitOut = (tState_r == TS_FCS) ? txCrc[tBit_r[3:0]] :
                   tCur[tBit_r[2:0]];
    wire txCrcEn = lclkFall && tState_r == TS_PAY;

    pfrm_crc16 uTxCrc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .init(txGo & ~txActive_r),
        .en(txCrcEn),
        .bitIn(tBitOut),
        .crc_r(txCrc)
    );

    // bits leave on the link clock falling edge, LSB first
    always @(posedge core_clk) begin
        if (!rst_n) begin
            tState_r <= TS_IDLE;
            tBit_r <= 5'h00;
            tByte_r <= 7'h00;
            txData_r <= 1'b0;
            txActive_r <= 1'b0;
        end else if (tState_r == TS_IDLE) begin
            if (txGo) begin
                tState_r <= TS_PRE;
                tBit_r <= 5'h00;
                tByte_r <= 7'h00;
            end
        end else if (lclkFall) begin
            txData_r <= tBitOut;
            txActive_r <= (tState_r != TS_TAIL);
            tBit_r <= tEnd ? 5'h00 : tBit_r + 5'h01;
            case (tState_r)
                // preamble, delimiter, length in that order
                TS_PRE: if (tEnd) tState_r <= TS_SFD;
                TS_SFD: if (tEnd) tState_r <= TS_LEN;
                TS_LEN: begin
                    if (tEnd) begin
                        tState_r <= (txLen_r == 7'h00) ? TS_FCS : TS_PAY;
                    end
                end
                TS_PAY: begin
                    if (tEnd) begin
                        tByte_r <= tByte_r + 7'h01;
                        // check sequence right after last byte
                        if (tByte_r == txLen_r - 7'h01) begin
                            tState_r <= TS_FCS;
                        end
                    end
                end
                TS_FCS: if (tEnd) tState_r <= TS_TAIL;
                default: begin
                    // Last bit has held a full link period
                    txData_r <= 1'b0;
                    tState_r <= TS_IDLE;
                end
            endcase
        end
    end
    wire txDoneSet = lclkFall && tState_r == TS_TAIL;

    // Receive parsing
    reg [1:0] rState_r;
    reg [7:0] rSh_r;            // Last eight bits, newest in bit 7
    reg [5:0] zeroCnt_r;        // Run of zero bits, saturating
    reg [3:0] since_r;          // Bits since the zero run ended
    reg preSeen_r;              // Preamble found, awaiting delimiter
    reg [2:0] rBit_r;
    reg [6:0] rByte_r;
    reg [15:0] lqiCnt_r;
    reg [7:0] lqiMax_r;
    wire [15:0] rxCrc;
    wire [7:0] rxByte = {rxBit, rSh_r[7:1]};
    wire rxCrcInit = lclkRise && rState_r == RS_LEN && rBit_r == 3'h7;
    wire rxCrcEn = lclkRise && rState_r == RS_PAY;
    wire preNow = lclkRise && !rxBit &&
                  zeroCnt_r == `PFRM_PRE_BITS - 6'h01;

    // receive check, running over payload and check sequence
    pfrm_crc16 uRxCrc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .init(rxCrcInit),
        .en(rxCrcEn),
        .bitIn(rxBit),
        .crc_r(rxCrc)
    );

    // hunt, length, then store bytes; bits taken on link rise
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rState_r <= RS_HUNT;
            rSh_r <= 8'h00;
            zeroCnt_r <= 6'h00;
            since_r <= 4'h0;
            preSeen_r <= 1'b0;
            rBit_r <= 3'h0;
            rByte_r <= 7'h00;
            rxLen_r <= 7'h00;
            crcOk_r <= 1'b0;
        end else if (!rxEn_r) begin
            rState_r <= RS_HUNT;
            preSeen_r <= 1'b0;
            zeroCnt_r <= 6'h00;
        end else if (rState_r == RS_FIN) begin
            // a zero residue means the frame checked good
            crcOk_r <= (rxCrc == 16'h0000);
            rState_r <= RS_HUNT;
        end else if (lclkRise) begin
            rSh_r <= rxByte;
            rBit_r <= rBit_r + 3'h1;
            case (rState_r)
                RS_HUNT: begin
                    rBit_r <= 3'h0;
                    if (!rxBit) begin
                        since_r <= 4'h0;
                        if (zeroCnt_r != `PFRM_PRE_BITS) begin
                            zeroCnt_r <= zeroCnt_r + 6'h01;
                        end
                    end else begin
                        zeroCnt_r <= 6'h00;
                        since_r <= since_r + 4'h1;
                    end
                    if (preNow) begin
                        preSeen_r <= 1'b1;
                    end else if (preSeen_r && rxByte == `PFRM_SFD) begin
                        preSeen_r <= 1'b0;
                        rState_r <= RS_LEN;
                    end else if (since_r == 4'h8) begin
                        preSeen_r <= 1'b0;
                    end
                end
                RS_LEN: begin
                    if (rBit_r == 3'h7) begin
                        rxLen_r <= rxByte[6:0];
                        rByte_r <= 7'h00;
                        // Too short to hold a check sequence: drop it
                        rState_r <= (rxByte[6:0] < `PFRM_MIN_LEN) ?
                                    RS_HUNT : RS_PAY;
                    end
                end
                RS_PAY: begin
                    if (rBit_r == 3'h7) begin
                        rByte_r <= rByte_r + 7'h01;
                        if (rByte_r == rxLen_r - 7'h01) begin
                            rState_r <= RS_FIN;
                        end
                    end
                end
                default: rState_r <= RS_HUNT;
            endcase
        end
    end
    wire rxDoneSet = rxEn_r && rState_r == RS_FIN;

    // link quality: peak energy over the window after preamble
    always @(posedge core_clk) begin
        if (!rst_n) begin
            lqiCnt_r <= 16'h0000;
            lqiMax_r <= 8'h00;
        end else if (rxEn_r && preNow && rState_r == RS_HUNT) begin
            lqiCnt_r <= LQI_CYC;
            lqiMax_r <= 8'h00;
        end else if (lqiCnt_r != 16'h0000) begin
            lqiCnt_r <= lqiCnt_r - 16'h0001;
            if (bbEnergy > lqiMax_r) begin
                lqiMax_r <= bbEnergy;
            end
        end
    end

    // low byte first; quality in top byte keeps both check bytes
    always @(posedge core_clk) begin
        if (rxEn_r && lclkRise && rState_r == RS_PAY && rBit_r == 3'h7) begin
            if (rByte_r[0]) begin
                rxRam[rByte_r[6:1]] <= {rxByte, rxRam[rByte_r[6:1]][7:0]};
            end else begin
                rxRam[rByte_r[6:1]] <= {8'h00, rxByte};
            end
        end else if (rxDoneSet) begin
            rxRam[`PFRM_LQI_WORD] <= {lqiMax_r, rxRam[`PFRM_LQI_WORD][7:0]};
        end
    end

    // channel check: energy summed over the integration interval
    reg [15:0] ccaCnt_r;
    reg [SUMW-1:0] ccaSum_r;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ccaCnt_r <= 16'h0000;
            ccaSum_r <= {SUMW{1'b0}};
            ccaLvl_r <= 8'h00;
        end else if (ccaGo) begin
            ccaCnt_r <= CCA_CYC;
            ccaSum_r <= {{(SUMW-8){1'b0}}, bbEnergy};
        end else if (ccaCnt_r != 16'h0000) begin
            ccaCnt_r <= ccaCnt_r - 16'h0001;
            ccaSum_r <= ccaSum_r + {{(SUMW-8){1'b0}}, bbEnergy};
            if (ccaCnt_r == 16'h0001) begin
                ccaLvl_r <= ccaSum_r[SUMW-2:SUMW-9];
            end
        end
    end
    wire ccaDoneSet = (ccaCnt_r == 16'h0001) && !ccaGo;

    // sticky events; a set in the clearing cycle wins
    always @(posedge core_clk) begin
        if (!rst_n) begin
            txDone_r <= 1'b0;
            rxDone_r <= 1'b0;
            ccaDone_r <= 1'b0;
            irqN_r <= 1'b1;
        end else begin
            txDone_r <= txDoneSet | (txDone_r & ~statRd);
            rxDone_r <= rxDoneSet | (rxDone_r & ~statRd);
            ccaDone_r <= ccaDoneSet | (ccaDone_r & ~statRd);
            irqN_r <= ~(txDone_r | rxDone_r | ccaDone_r);
        end
    end
endmodule

// ==== pfrm_framer_sva.sv ====
`timescale 1ns/1ps
// Port-level checks on the framer, core clock domain only
module pfrm_framer_sva (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Host serial port
    input wire spiClk,
    input wire spiCsN,
    input wire spiMosi,
    input wire spiMiso_r,
    input wire spiMisoEn_r,
    input wire irqN_r,
    // Link side
    input wire linkClk,
    input wire linkRxData,
    input wire txData_r,
    input wire txActive_r,
    input wire [7:0] bbEnergy
);
    localparam int PRE_CYC = 1000; // Below 32 link bits of 32 cycles
    localparam int MIN_CYC = 2000; // Below 64 bits of shortest frame
    logic [15:0] txCyc_r; // Cycles since frame start
    logic [15:0] txCyc_nxt;

    // Saturating frame length counter
    always @* begin
        txCyc_nxt = txCyc_r;
        if (!txActive_r) txCyc_nxt = 16'h0000;
        else if (txCyc_r != 16'hFFFF) txCyc_nxt = txCyc_r + 16'h0001;
    end
    always @(posedge core_clk) begin
        if (!rst_n) txCyc_r <= 16'h0000;
        else txCyc_r <= txCyc_nxt;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_txEnd;
        $fell(txActive_r);
    endsequence
    sequence s_irqSoon;
        ##[0:3] !irqN_r;
    endsequence

    property p_resetIdle;
        $rose(rst_n) |-> irqN_r && !txActive_r && !txData_r && !spiMisoEn_r;
    endproperty
    a_resetIdle: assert property (p_resetIdle)
        else $error("outputs not idle after reset");
    property p_txIdle;
        !txActive_r |-> !txData_r;
    endproperty
    a_txIdle: assert property (p_txIdle)
        else $error("transmit line busy outside a frame");
    property p_preamble;
        txActive_r && txCyc_r < PRE_CYC |-> !txData_r;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("preamble bit not zero");
    property p_frameLen;
        s_txEnd |-> txCyc_r >= MIN_CYC;
    endproperty
    a_frameLen: assert property (p_frameLen)
        else $error("frame shorter than header and check sequence");
    property p_txIrq;
        s_txEnd |-> s_irqSoon;
    endproperty
    a_txIrq: assert property (p_txIrq)
        else $error("no interrupt after frame sent");
    property p_txEdge;
        $changed(txData_r) |-> !linkClk;
    endproperty
    a_txEdge: assert property (p_txEdge)
        else $error("transmit bit changed while link clock high");
    property p_selOff;
        spiCsN [*8] |-> !spiMisoEn_r;
    endproperty
    a_selOff: assert property (p_selOff)
        else $error("read line driven while deselected");
    property p_selOn;
        !spiCsN [*8] |-> spiMisoEn_r;
    endproperty
    a_selOn: assert property (p_selOn)
        else $error("read line not driven while selected");
    property p_irqHold;
        !irqN_r && spiCsN |=> !irqN_r;
    endproperty
    a_irqHold: assert property (p_irqHold)
        else $error("interrupt cleared without status read");
endmodule

// ==== pfrm_framer_tb.sv ====
`timescale 1ns/1ps
`include "pfrm_regs.vh"
module pfrm_framer_tb;
    logic core_clk;
    logic rst_n;
    logic linkClk; // Free running link bit clock
    logic linkRxData;
    logic [7:0] bbEnergy;
    logic idleMiso = 1'b0; // Toggles while released
    logic [15:0] rd; // Last word read over the port
    wire spiClk, spiCsN, spiMosi, spiMiso_r, spiMisoEn_r;
    wire irqN_r, txData_r, txActive_r;
    wire misoLine = spiMisoEn_r ? spiMiso_r : idleMiso;
    int num_errors = 0;
    int n_checks = 0;

    // Short windows keep the run brief
    pfrm_framer #(.LQI_CYC(16'h0040), .CCA_CYC(16'h0100)) u_pfrm_framer (
        .core_clk(core_clk), .rst_n(rst_n), .spiClk(spiClk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso_r(spiMiso_r),
        .spiMisoEn_r(spiMisoEn_r), .irqN_r(irqN_r), .linkClk(linkClk),
        .linkRxData(linkRxData), .txData_r(txData_r),
        .txActive_r(txActive_r), .bbEnergy(bbEnergy));
    pfrm_host_model u_pfrm_host_model (.core_clk(core_clk),
        .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(misoLine));

    // Core clock, 5 ns
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Link clock, 160 ns, offset so edges never meet core edges
    initial begin
        linkClk = 1'b0;
        #37;
        forever #80 linkClk = ~linkClk;
    end
    always @(posedge core_clk) idleMiso <= ~idleMiso;

    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic spi(input logic [7:0] cmd, input logic [15:0] wd);
        u_pfrm_host_model.xfer(cmd, wd, rd);
    endtask
    // Reflected check sequence, one byte, low bit first
    function automatic logic [15:0] crcByte(input logic [15:0] c,
            input logic [7:0] b);
        int i;
        for (i = 0; i < 8; i++) begin
            if (c[0] ^ b[i]) c = (c >> 1) ^ `PFRM_CRC_POLY;
            else c = c >> 1;
        end
        return c;
    endfunction
    // Bounded wait for the interrupt line to go low
    task automatic waitIrq(int lim);
        int k;
        for (k = 0; k < lim && irqN_r !== 1'b0; k++) @(posedge core_clk);
        chk("irqLow", 16'h0000, {15'h0000, irqN_r});
    endtask
    // Received bits change just after a link fall, low bit first
    task automatic sendByte(logic [7:0] b);
        int i;
        for (i = 0; i < 8; i++) begin
            @(negedge linkClk);
            @(posedge core_clk) linkRxData <= b[i];
        end
    endtask

    task automatic testReset;
        chk("resetOut", 16'h0010, {11'h000, irqN_r, txActive_r, txData_r,
            spiMisoEn_r, spiMiso_r});
    endtask

    // Three-byte payload: header, payload and check sequence on the wire
    task automatic testTx;
        logic [7:0] exp [11];
        logic [7:0] got;
        logic [15:0] crc;
        int i, k;
        crc = crcByte(crcByte(crcByte(`PFRM_CRC_INIT, 8'h11), 8'h22), 8'h33);
        exp = '{8'h00, 8'h00, 8'h00, 8'h00, `PFRM_SFD, 8'h05, 8'h11, 8'h22,
            8'h33, crc[7:0], crc[15:8]};
        spi(8'h40, 16'h2211);
        spi(8'h41, 16'h0033);
        spi(8'h7F, 16'hBEEF); // Must not reach the receive side
        fork
            spi(8'h00, 16'h0301);
            begin
                for (k = 0; k < 3000 && txActive_r !== 1'b1; k++)
                    @(posedge core_clk);
                for (i = 0; i < 11; i++) begin
                    for (k = 0; k < 8; k++) begin
                        @(posedge linkClk);
                        got[k] = txData_r;
                    end
                    chk("txByte", {8'h00, exp[i]}, {8'h00, got});
                end
            end
        join
        waitIrq(300);
        spi(8'h81, 16'h0000);
        chk("txStatus", 16'h0001, rd & 16'h0013);
        chk("irqClear", 16'h0001, {15'h0000, irqN_r});
    endtask

    // Receive one frame, good or with a damaged check sequence
    task automatic testRx(input logic bad);
        logic [7:0] pl [5];
        logic [15:0] crc;
        int i;
        crc = crcByte(crcByte(crcByte(16'h0000, 8'hC3), 8'h3C), 8'h81);
        pl = '{8'hC3, 8'h3C, 8'h81, crc[7:0] ^ {7'h00, bad}, crc[15:8]};
        spi(8'h00, 16'h0002);
        for (i = 0; i < 4; i++) sendByte(8'h00);
        sendByte(`PFRM_SFD);
        sendByte(8'h05);
        for (i = 0; i < 4; i++) sendByte(pl[i]);
        chk("irqEarly", 16'h0001, {15'h0000, irqN_r});
        sendByte(pl[4]);
        @(negedge linkClk);
        @(posedge core_clk) linkRxData <= 1'b1;
        waitIrq(300);
        spi(8'h81, 16'h0000);
        chk("rxStatus", {8'h05, 5'h00, ~bad, 2'b10}, rd & 16'h7F06);
        spi(8'hC0, 16'h0000);
        chk("rxWord0", {pl[1], pl[0]}, rd);
        spi(8'hC1, 16'h0000);
        chk("rxWord1", {pl[3], pl[2]}, rd);
        spi(8'hC2, 16'h0000);
        chk("rxWord2", {8'h00, pl[4]}, rd);
        spi(8'hFF, 16'h0000);
        chk("linkQual", 16'h5A00, rd & 16'hFF00);
        spi(8'h00, 16'h0000);
    endtask

    // Channel check: 256 cycles of level 0x80 give 1 in bits 22..15
    task automatic testCca;
        @(posedge core_clk) bbEnergy <= 8'h80;
        spi(8'h00, 16'h0004);
        waitIrq(2000);
        spi(8'h81, 16'h0000);
        chk("ccaDone", 16'h0008, rd & 16'h0008);
        spi(8'h82, 16'h0000);
        chk("ccaLevel", 16'h0001, rd & 16'h00FF);
        @(posedge core_clk) bbEnergy <= 8'h5A;
    endtask

    // Overlong payload length is clamped
    task automatic testClamp;
        spi(8'h00, 16'h7F00);
        spi(8'h80, 16'h0000);
        chk("lenClamp", 16'h7D00, rd);
    endtask

    task conclude;
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence, reset held for 12 edges
    initial begin
        rst_n = 1'b0;
        linkRxData = 1'b1;
        bbEnergy = 8'h5A;
        repeat (11) @(posedge core_clk);
        testReset;
        @(posedge core_clk) rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        testTx;
        testRx(1'b0);
        testRx(1'b1);
        testCca;
        testClamp;
        conclude;
    end
    // Watchdog, about four times the expected run
    initial begin
        #400000;
        num_errors++;
        conclude;
    end
endmodule

bind pfrm_framer pfrm_framer_sva u_pfrm_framer_sva (
    .core_clk(core_clk), .rst_n(rst_n), .spiClk(spiClk),
    .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso_r(spiMiso_r),
    .spiMisoEn_r(spiMisoEn_r), .irqN_r(irqN_r), .linkClk(linkClk),
    .linkRxData(linkRxData), .txData_r(txData_r),
    .txActive_r(txActive_r), .bbEnergy(bbEnergy));

// ==== pfrm_host_model.sv ====
`timescale 1ns/1ps
// Host side of the serial port, paced by the core clock
module pfrm_host_model (
    // Clock
    input wire logic core_clk,
    // Serial port
    output logic spiClk,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso
);
    // Idle bus: clock low, select high
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end

    // one whole 24-bit transfer
    // Half period of 10 cycles keeps clear of the sync latency
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
            output logic [15:0] rd);
        logic [23:0] sh;
        int i;
        sh = {cmd, wd};
        rd = 16'h0000;
        @(posedge core_clk) spiCsN <= 1'b0;
        for (i = 23; i >= 0; i--) begin
            repeat (10) @(posedge core_clk);
            spiClk <= 1'b0;
            spiMosi <= sh[i];
            repeat (10) @(posedge core_clk);
            spiClk <= 1'b1;
            // Read bits taken at rises 9..24
            if (i < 16) rd = {rd[14:0], spiMiso};
        end
        repeat (10) @(posedge core_clk);
        spiClk <= 1'b0;
        // No stale data bit left
        spiMosi <= ~spiMosi;
        repeat (10) @(posedge core_clk);
        spiCsN <= 1'b1;
        repeat (10) @(posedge core_clk);
    endtask
endmodule

// ==== pfrm_regs.vh ====
`ifndef PFRM_REGS_VH
`define PFRM_REGS_VH
// Core clock rate and timing windows
`define PFRM_CLK_MHZ 200
`define PFRM_LQI_WIN_US 64
`define PFRM_LQI_CYC (`PFRM_LQI_WIN_US * `PFRM_CLK_MHZ)
`define PFRM_CCA_WIN_US 128
`define PFRM_CCA_CYC (`PFRM_CCA_WIN_US * `PFRM_CLK_MHZ)
// Packet buffers
`define PFRM_RAM_WORDS 64
`define PFRM_WORD_BITS 16
`define PFRM_LQI_WORD 6'h3F
// Frame layout
`define PFRM_MAX_PAYLOAD 7'h7D
`define PFRM_FCS_BYTES 8'h02
`define PFRM_MIN_LEN 7'h02
`define PFRM_PRE_BITS 6'h20
`define PFRM_SFD 8'hA7
// Check sequence, reflected form, shifted LSB first
`define PFRM_CRC_POLY 16'h8408
`define PFRM_CRC_INIT 16'h0000
// Serial port addresses (bit 6 selects a packet buffer)
`define PFRM_ADDR_CTRL 7'h00
`define PFRM_ADDR_STAT 7'h01
`define PFRM_ADDR_CCA 7'h02
`define PFRM_RAM_SEL 6
// Control word fields
`define PFRM_CTRL_TXGO 0
`define PFRM_CTRL_RXEN 1
`define PFRM_CTRL_CCAGO 2
// Status word fields
`define PFRM_STAT_TXDONE 0
`define PFRM_STAT_RXDONE 1
`define PFRM_STAT_CRCOK 2
`define PFRM_STAT_CCADONE 3
`define PFRM_STAT_TXBUSY 4
// Serial transfer length
`define PFRM_CMD_BITS 5'h08
`define PFRM_SPI_BITS 5'h18
`endif
